/* File: sim/slsp_host.sv */
`timescale 1ns/1ps
module slsp_host
	import slsp_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic [7:0] rdata,
	input  wire logic       data_oe_n,
	output slsp_bus_s       bus
);
	logic ex = 1'b1;
	initial bus = '0;
	// plain cycle, no setup sequence; released address and data lines show the inverse, strobes go low
	task cyc(input logic [7:0] a, d, input logic w,
		output logic [7:0] q, output logic oe);
		@(negedge core_clk);
		bus = '{a, d, 1'b1, !w, w, ex};
		repeat (5) @(negedge core_clk);
		q = rdata;
		oe = data_oe_n;
		bus = '{~a, ~d, 1'b0, 1'b0, 1'b0, ex};
		repeat (2) @(negedge core_clk);
	endtask : cyc
endmodule : slsp_host

/* File: sim/tb_slsp_port.sv */
`timescale 1ns/1ps
module tb_slsp_port
	import slsp_pkg::*;
;
	logic           core_clk   = 1'b0;
	logic           arst_n     = 1'b0;
	logic           sysreset_n = 1'b1;
	logic [4:0]     base_sel   = 5'h15;
	slsp_exp_mode_e exp_mode   = SLSP_EXP_IGNORE;
	logic [31:0]    sw_in      = 32'h12FE80A5;
	logic [31:0]    led_out, exp_led;
	logic [7:0]     rdata, q;
	logic           data_oe_n, oe, hit;
	slsp_bus_s      bus;
	int             fail_count = 0;
	int             compares   = 0;
	initial forever #25 core_clk = ~core_clk;
	slsp_port i_slsp_port (.core_clk(core_clk), .arst_n(arst_n),
		.sysreset_n(sysreset_n), .bus(bus), .base_sel(base_sel),
		.exp_mode(exp_mode), .sw_in(sw_in), .rdata(rdata),
		.data_oe_n(data_oe_n), .led_out(led_out));
	slsp_host i_slsp_host (.core_clk(core_clk), .rdata(rdata),
		.data_oe_n(data_oe_n), .bus(bus));
	task chk(input string n, input logic [31:0] g, e);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task io(input logic [2:0] p, input logic [7:0] d, input logic w);
		i_slsp_host.cyc({base_sel, p}, d, w, q, oe);
	endtask : io
	task t_led;
		chk("reset leds", led_out, 32'h0);
		for (int p = 0; p < 4; p++)
		begin
			io(p[2:0], 8'h5A + p[7:0], 1'b1);
			exp_led[8*p+:8] = 8'h5A + p[7:0];
		end
		chk("leds", led_out, exp_led);
		io(3'h0, 8'h00, 1'b0);
		chk("led read oe", oe, 1'b1);
		chk("led read", led_out, exp_led);
	endtask : t_led
	task t_sw;
		for (int k = 0; k < 2; k++)
		begin
			if (k == 1)
			begin
				sw_in = 32'h6D017F5A;
				repeat (4) @(negedge core_clk);
			end
			for (int p = 4; p < 8; p++)
			begin
				io(p[2:0], 8'h00, 1'b0);
				chk("sw oe", oe, 1'b0);
				chk("sw", q, sw_in[8*(p-4)+:8]);
			end
		end
		io(3'h5, 8'hFF, 1'b1);
		chk("sw write", led_out, exp_led);
		chk("sw write oe", oe, 1'b1);
	endtask : t_sw
	task t_dec;
		i_slsp_host.cyc(8'hB1, 8'hFF, 1'b1, q, oe);
		chk("other base", led_out, exp_led);
		for (int m = 0; m < 6; m++)
		begin
			exp_mode = slsp_exp_mode_e'(m / 2);
			i_slsp_host.ex = m[0];
			hit = (m > 3) || (m == 1) || (m == 2);
			io(3'h1, 8'h10 + m[7:0], 1'b1);
			if (hit)
				exp_led[15:8] = 8'h10 + m[7:0];
			chk("exp mode", led_out, exp_led);
		end
		base_sel = 5'h00;
		io(3'h2, 8'h77, 1'b1);
		exp_led[23:16] = 8'h77;
		chk("new base", led_out, exp_led);
		i_slsp_host.cyc(8'hAA, 8'h99, 1'b1, q, oe);
		chk("old base", led_out, exp_led);
		base_sel = 5'h15;
	endtask : t_dec
	task t_rst;
		sysreset_n = 1'b0;
		repeat (4) @(negedge core_clk);
		chk("sysreset", led_out, 32'h0);
		sysreset_n = 1'b1;
		repeat (4) @(negedge core_clk);
		io(3'h3, 8'hC3, 1'b1);
		chk("after reset", led_out, 32'hC3000000);
		arst_n = 1'b0;
		@(negedge core_clk);
		chk("power-on reset", led_out, 32'h0);
		arst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		io(3'h0, 8'h81, 1'b1);
		chk("after power-on", led_out, 32'h00000081);
		io(3'h7, 8'h00, 1'b0);
		chk("read after power-on", q, sw_in[31:24]);
	endtask : t_rst
	task finish_test;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (2) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		t_led;
		t_sw;
		t_dec;
		t_rst;
		finish_test;
	end
	initial
	begin
		#100000;
		fail_count++;
		finish_test;
	end
endmodule : tb_slsp_port

/* File: src/slsp_pkg.sv */
package slsp_pkg;

	// window geometry
	localparam int unsigned  PORT_COUNT    = 8;
	localparam int unsigned  GROUP_COUNT   = 4;
	localparam int unsigned  ADDR_W        = 8;
	localparam int unsigned  DATA_W        = 8;
	localparam logic [2:0]   LED_PORT_BASE = 3'h0;
	localparam logic [2:0]   SW_PORT_BASE  = 3'h4;
	localparam logic [7:0]   LED_RST       = 8'h00;
	localparam logic [7:0]   SW_RST        = 8'hFF;

	// bus-side timing, the 12 MHz limit of the backplane
	localparam int unsigned  BUS_MAX_MHZ   = 12;
	localparam int unsigned  CORE_MHZ      = 20;
	localparam int unsigned  CORE_PER_BUS  = CORE_MHZ / BUS_MAX_MHZ;

	typedef enum logic [1:0] {
		SLSP_EXP_HIGH,
		SLSP_EXP_LOW,
		SLSP_EXP_IGNORE
	} slsp_exp_mode_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       iorq;
		logic       rd;
		logic       wr;
		logic       ioexp;
	} slsp_bus_s;

endpackage : slsp_pkg

/* File: src/slsp_port.sv */
`timescale 1ns/1ps
// How it works
// R1 - card answers to eight consecutive ports on an eight-port aligned base
// R2 - selected when address bits 7..3 match the strapped base
// R3 - ioexp qualifies the decode: active high, active low or ignored
// R4 - window splits into four input and four output ports
// R5 - ports 0-3 are led outputs, ports 4-7 are switch inputs
// R6 - a switch port read returns its eight switches uninverted
// R7 - open switch reads one, closed (grounded) switch reads zero
// R8 - thirty-two switch inputs in four groups of eight
// R9 - write to a led port latches the byte until the next write
// R10 - system reset and power-on reset clear all led latches
// R11 - no setup needed; ports usable right after reset
// R12 - bus cycles up to 12 MHz are handled
// R13 - a latched one lights its led, zero leaves it dark
// R14 - switch writes and led reads change nothing; no drive on writes
module slsp_port
	import slsp_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 arst_n,
	input  wire logic                 sysreset_n,
	input  wire slsp_bus_s            bus,
	input  wire logic [4:0]           base_sel,
	input  wire slsp_exp_mode_e       exp_mode,
	input  wire logic [31:0]          sw_in,
	output logic      [7:0]           rdata,
	output logic                      data_oe_n,
	output logic      [31:0]          led_out
);

	slsp_bus_s          bus_q1, bus_q2, bus_q3;
	logic [31:0]        sw_q1, sw_q2, sw_q3, sw_q;
	logic               srst_q1, srst_q2, srst_q3;
	logic               rd_st_q, wr_st_q;
	logic               exp_ok, base_hit, sel;
	logic               rd_now, wr_now, rd_go, wr_go;
	logic [2:0]         port;

	// three-stage synchronisers; stage two and three must agree
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_q1  <= '0;
			bus_q2  <= '0;
			bus_q3  <= '0;
			sw_q1   <= {32{1'b1}};
			sw_q2   <= {32{1'b1}};
			sw_q3   <= {32{1'b1}};
			srst_q1 <= 1'b0;
			srst_q2 <= 1'b0;
			srst_q3 <= 1'b0;
		end
		else
		begin
			bus_q1  <= bus;
			bus_q2  <= bus_q1;
			bus_q3  <= bus_q2;
			sw_q1   <= sw_in;
			sw_q2   <= sw_q1;
			sw_q3   <= sw_q2;
			srst_q1 <= sysreset_n;
			srst_q2 <= srst_q1;
			srst_q3 <= srst_q2;
		end
	end

	// per-bit agreement filter for the switches
	generate
		for (genvar i = 0; i < 32; i++)
		begin : g_sw
			always_ff @(posedge core_clk or negedge arst_n)
			begin
				if (!arst_n)
					sw_q[i] <= 1'b1;
				else if (sw_q2[i] == sw_q3[i])
					sw_q[i] <= sw_q3[i]; // see R7
			end
		end
	endgenerate

	always_comb
	begin
		case (exp_mode) // see R3
			SLSP_EXP_HIGH:   exp_ok = bus_q3.ioexp & bus_q2.ioexp;
			SLSP_EXP_LOW:    exp_ok = ~bus_q3.ioexp & ~bus_q2.ioexp;
			SLSP_EXP_IGNORE: exp_ok = 1'b1;
			default:         exp_ok = 1'b0;
		endcase
	end

	// 5-bit match of addr[7:3] against base_sel, low three bits pick the port
	assign base_hit = (bus_q3.addr[7:3] == base_sel) &&
	                  (bus_q2.addr == bus_q3.addr); // see R1, R2
	assign sel      = base_hit && exp_ok && bus_q3.iorq && bus_q2.iorq;
	assign port     = bus_q3.addr[2:0];
	assign rd_now   = sel && bus_q3.rd && bus_q2.rd;
	assign wr_now   = sel && bus_q3.wr && bus_q2.wr &&
	                  (bus_q2.wdata == bus_q3.wdata);
	// writes act once per strobe via wr_go, so slow cycles latch once; reads follow rd_now each cycle, rd_go only feeds a_rd_start
	assign rd_go    = rd_now && !rd_st_q; // see R12
	assign wr_go    = wr_now && !wr_st_q;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_st_q <= 1'b0;
			wr_st_q <= 1'b0;
		end
		else
		begin
			rd_st_q <= rd_now;
			wr_st_q <= wr_now;
		end
	end

	// led latches: writes to ports 0-3 only; cleared by either reset
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			led_out <= {GROUP_COUNT{LED_RST}}; // see R10, R11
		else if (!srst_q3 && !srst_q2)
			led_out <= {GROUP_COUNT{LED_RST}}; // see R10
		else if (wr_go && port[2] == LED_PORT_BASE[2]) // see R5, R14
			led_out[port[1:0]*8 +: 8] <= bus_q3.wdata; // see R9, R13
	end

	// read path: only switch ports drive, and only while read holds
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata     <= SW_RST;
			data_oe_n <= 1'b1;
		end
		else if (rd_now && port[2] == SW_PORT_BASE[2]) // see R4, R5, R14
		begin
			rdata     <= sw_q[port[1:0]*8 +: 8]; // see R6, R8
			data_oe_n <= 1'b0;
		end
		else
		begin
			rdata     <= rdata;
			data_oe_n <= 1'b1;
		end
	end

	property p_led_write;
		@(posedge core_clk) disable iff (!arst_n)
		(wr_go && !port[2] && srst_q3 && srst_q2) |=>
			led_out[$past(port[1:0])*8 +: 8] == $past(bus_q3.wdata);
	endproperty
	a_led_write: assert property (p_led_write) // see R9
		else $error("led byte not latched");

	property p_led_clear;
		@(posedge core_clk) disable iff (!arst_n)
		(!srst_q3 && !srst_q2) |=> led_out == 32'h0000_0000;
	endproperty
	a_led_clear: assert property (p_led_clear) // see R10
		else $error("leds not cleared by system reset");

	property p_led_hold;
		@(posedge core_clk) disable iff (!arst_n)
		(!wr_go && srst_q3 && srst_q2) |=> $stable(led_out);
	endproperty
	a_led_hold: assert property (p_led_hold) // see R14
		else $error("leds changed without a write");

	property p_sw_read;
		@(posedge core_clk) disable iff (!arst_n)
		(rd_now && port[2]) |=>
			!data_oe_n && rdata == $past(sw_q[port[1:0]*8 +: 8]);
	endproperty
	a_sw_read: assert property (p_sw_read) // see R6
		else $error("switch read data wrong");

	property p_no_drive_led_rd;
		@(posedge core_clk) disable iff (!arst_n)
		(!rd_now || !port[2]) |=> data_oe_n;
	endproperty
	a_no_drive_led_rd: assert property (p_no_drive_led_rd) // see R14
		else $error("bus driven outside a switch read");

	property p_exp_low;
		@(posedge core_clk) disable iff (!arst_n)
		(exp_mode == SLSP_EXP_LOW && bus_q3.ioexp) |-> !sel;
	endproperty
	a_exp_low: assert property (p_exp_low) // see R3
		else $error("selected with ioexp high in low mode");

	property p_base;
		@(posedge core_clk) disable iff (!arst_n)
		(bus_q3.addr[7:3] != base_sel && srst_q3 && srst_q2) |=>
			$stable(led_out);
	endproperty
	a_base: assert property (p_base) // see R2
		else $error("leds changed by a cycle outside the window");

	property p_sw_filter;
		@(posedge core_clk) disable iff (!arst_n)
		(sw_q2[0] != sw_q3[0]) |=> $stable(sw_q[0]);
	endproperty
	a_sw_filter: assert property (p_sw_filter) // see R7
		else $error("switch bit moved before stages agreed");

	property p_sw_track;
		@(posedge core_clk) disable iff (!arst_n)
		(sw_q2[0] == sw_q3[0]) |=> sw_q[0] == $past(sw_q3[0]);
	endproperty
	a_sw_track: assert property (p_sw_track) // see R7
		else $error("switch bit did not follow agreed stages");

	property p_rd_start;
		@(posedge core_clk) disable iff (!arst_n)
		(rd_go && port[2] == SW_PORT_BASE[2]) |=> $fell(data_oe_n);
	endproperty
	a_rd_start: assert property (p_rd_start) // see R12
		else $error("read strobe did not start driving");

	property p_wr_no_drive;
		@(posedge core_clk) disable iff (!arst_n)
		wr_now |=> data_oe_n;
	endproperty
	a_wr_no_drive: assert property (p_wr_no_drive) // see R14
		else $error("bus driven during a write");

endmodule : slsp_port
